// >>> rtl/sfpc_defines.vh
`ifndef SFPC_DEFINES_VH
`define SFPC_DEFINES_VH

// Clock rate
`define SFPC_MCLK_KHZ 40000

// Idle pin levels {data, clock, select}
`define SFPC_PIN_IDLE 3'h1

// Self-timed cycle maxima, printed units
`define SFPC_WB_MAX_MS 5
`define SFPC_WS_MAX_MS 15
`define SFPC_EB_MAX_S 10
`define SFPC_ES_MAX_S 3

// Command codes and status fields
`define SFPC_OP_WREN 8'h06
`define SFPC_OP_WRDI 8'h04
`define SFPC_OP_RDSR 8'h05
`define SFPC_OP_WRSR 8'h01
`define SFPC_OP_READ 8'h03
`define SFPC_OP_RDID 8'hab
`define SFPC_OP_WRITE 8'h02
`define SFPC_OP_EBULK 8'hc7
`define SFPC_OP_ESECT 8'hd8
`define SFPC_SR_BUSY_BIT 0
`define SFPC_SR_WEL_BIT 1

// Self-timed job kinds
`define SFPC_JOB_WB 2'h0
`define SFPC_JOB_WS 2'h1
`define SFPC_JOB_EB 2'h2
`define SFPC_JOB_ES 2'h3

`endif

// >>> rtl/sfpc_flash.v
// Function
// - Select low: enabled, active, accepting traffic
// - Select high: disabled, active until cycle done
// - Byte write finishes within 5 ms
// - Status write finishes within 15 ms
// - Bulk erase finishes within its bound
// - Sector erase finishes within 3 s
// - Sample serial input on rising clock
// - Drive output after falling edge; release
// - Busy flag set during self-timed cycles
`timescale 1ns/1ps
`default_nettype none
`include "sfpc_defines.vh"
module sfpc_flash #(
    parameter WB_CYC = `SFPC_WB_MAX_MS * `SFPC_MCLK_KHZ,
    parameter WS_CYC = `SFPC_WS_MAX_MS * `SFPC_MCLK_KHZ,
    parameter EB_CYC = `SFPC_EB_MAX_S * 1000 * `SFPC_MCLK_KHZ,
    parameter ES_CYC = `SFPC_ES_MAX_S * 1000 * `SFPC_MCLK_KHZ,
    parameter [7:0] SILICON_ID = 8'h5a // Arbitrary value
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Serial port pins
    input wire chip_select_low,
    input wire serial_clock_in,
    input wire serial_command_in,
    output reg serial_data_out,
    output reg serial_data_oe,
    // Power and progress status
    output wire active_power,
    output wire port_enabled,
    output wire cycle_busy,
    // Array-side strobes
    output reg [23:0] array_addr,
    output reg [7:0] array_wdata,
    output reg array_wstrobe,
    input wire [7:0] array_rdata,
    output reg [1:0] job_kind,
    output reg job_start
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_BUSY = 3'b100;

    wire [2:0] lvl;
    wire [2:0] rise;
    wire [2:0] fall;
    reg [2:0] state;
    reg [7:0] sh;
    reg [2:0] bitc;
    reg [7:0] op;
    reg [2:0] bytec;
    reg [23:0] addr;
    reg [7:0] outsh;
    reg wel;
    reg [7:0] srbits;
    reg pend_valid;
    reg [1:0] pend_kind;
    reg [31:0] timer;
    reg [7:0] next_sh;

    // Pin filtering: select, clock, data
    sfpc_sync #(.WIDTH(3), .INIT(`SFPC_PIN_IDLE)) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .raw({serial_command_in, serial_clock_in, chip_select_low}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    wire sel = ~lvl[0];
    wire sclk_rise = rise[1] & sel;
    wire sclk_fall = fall[1] & sel;
    wire sel_end = rise[0];
    wire busy = (state == ST_BUSY);
    wire [7:0] status = {6'h00, wel, busy};

    assign port_enabled = sel;
    assign active_power = sel | busy;
    assign cycle_busy = busy;

    // Duration of each self-timed job
    function [31:0] job_len;
        input [1:0] k;
        begin
            case (k)
                `SFPC_JOB_WB: job_len = WB_CYC;
                `SFPC_JOB_WS: job_len = WS_CYC;
                `SFPC_JOB_EB: job_len = EB_CYC;
                default: job_len = ES_CYC;
            endcase
        end
    endfunction

    // Byte being assembled on this rising edge
    always @* begin
        next_sh = {sh[6:0], lvl[2]};
    end

    // Command decode, self-timed cycles
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            sh <= 8'h00;
            bitc <= 3'h0;
            op <= 8'h00;
            bytec <= 3'h0;
            addr <= 24'h000000;
            wel <= 1'b0;
            srbits <= 8'h00;
            pend_valid <= 1'b0;
            pend_kind <= `SFPC_JOB_WB;
            timer <= 32'h0;
            array_addr <= 24'h000000;
            array_wdata <= 8'h00;
            array_wstrobe <= 1'b0;
            job_kind <= `SFPC_JOB_WB;
            job_start <= 1'b0;
        end else begin
            array_wstrobe <= 1'b0;
            job_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    bitc <= 3'h0;
                    bytec <= 3'h0;
                    pend_valid <= 1'b0;
                    if (sel) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sclk_rise) begin
                        sh <= next_sh;
                        bitc <= bitc + 3'h1;
                        if (bitc == 3'h7) begin
                            pend_valid <= 1'b0;
                            if (bytec != 3'h7) begin
                                bytec <= bytec + 3'h1;
                            end
                            if (bytec == 3'h0) begin
                                op <= next_sh;
                                if (next_sh == `SFPC_OP_WREN) begin
                                    wel <= 1'b1;
                                end
                                if (next_sh == `SFPC_OP_WRDI) begin
                                    wel <= 1'b0;
                                end
                                if (next_sh == `SFPC_OP_EBULK && wel) begin
                                    pend_valid <= 1'b1;
                                    pend_kind <= `SFPC_JOB_EB;
                                end
                            end else if (bytec < 3'h4) begin
                                addr <= {addr[15:0], next_sh};
                                if (bytec == 3'h3 && op == `SFPC_OP_ESECT && wel) begin
                                    pend_valid <= 1'b1;
                                    pend_kind <= `SFPC_JOB_ES;
                                end
                            end else begin
                                addr <= addr + 24'h000001;
                            end
                            if (bytec == 3'h1 && op == `SFPC_OP_WRSR && wel) begin
                                srbits <= next_sh;
                                pend_valid <= 1'b1;
                                pend_kind <= `SFPC_JOB_WS;
                            end
                            if (bytec >= 3'h4 && op == `SFPC_OP_WRITE && wel) begin
                                array_addr <= addr;
                                array_wdata <= next_sh;
                                array_wstrobe <= 1'b1;
                                pend_valid <= 1'b1;
                                pend_kind <= `SFPC_JOB_WB;
                            end
                        end
                    end
                    if (sclk_rise && bitc != 3'h7) begin
                        pend_valid <= 1'b0;
                    end
                    // Select rising starts the job at once; counters cleared for polling
                    if (sel_end) begin
                        bitc <= 3'h0;
                        bytec <= 3'h0;
                        if (pend_valid) begin
                            state <= ST_BUSY;
                            timer <= job_len(pend_kind);
                            job_kind <= pend_kind;
                            job_start <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_BUSY: begin
                    // Status polling still allowed while busy
                    if (sel_end) begin
                        bitc <= 3'h0;
                        bytec <= 3'h0;
                    end else if (sclk_rise) begin
                        bitc <= bitc + 3'h1;
                        sh <= next_sh;
                        if (bitc == 3'h7 && bytec == 3'h0) begin
                            op <= next_sh;
                            bytec <= 3'h1;
                        end
                    end
                    if (timer <= 32'h1) begin
                        state <= ST_IDLE;
                        wel <= 1'b0;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Output shifter: loads on falling edges
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            outsh <= 8'h00;
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
        end else begin
            if (!sel) begin
                serial_data_oe <= 1'b0;
            end else if (sclk_fall && bytec != 3'h0) begin
                serial_data_oe <= 1'b1;
                if (bitc == 3'h0) begin
                    if (op == `SFPC_OP_RDSR) begin
                        serial_data_out <= status[7];
                        outsh <= {status[6:0], 1'b0};
                    end else if (op == `SFPC_OP_RDID && !busy) begin
                        serial_data_out <= SILICON_ID[7];
                        outsh <= {SILICON_ID[6:0], 1'b0};
                    end else if (op == `SFPC_OP_READ && !busy && bytec >= 3'h4) begin
                        serial_data_out <= array_rdata[7];
                        outsh <= {array_rdata[6:0], 1'b0};
                    end else begin
                        serial_data_out <= outsh[7];
                        outsh <= {outsh[6:0], 1'b0};
                    end
                end else begin
                    serial_data_out <= outsh[7];
                    outsh <= {outsh[6:0], 1'b0};
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/sfpc_sync.v
`timescale 1ns/1ps
`default_nettype none
module sfpc_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Raw and filtered levels
    input wire [WIDTH-1:0] raw,
    output reg [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] s1;
    reg [WIDTH-1:0] s2;
    reg [WIDTH-1:0] s3;
    reg [WIDTH-1:0] prev;
    genvar i;

    // Three stages; reset to idle level so no false edge follows reset
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    s1[i] <= INIT[i];
                    s2[i] <= INIT[i];
                    s3[i] <= INIT[i];
                    level[i] <= INIT[i];
                    prev[i] <= INIT[i];
                end else begin
                    s1[i] <= raw[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        level[i] <= s3[i];
                    end
                    prev[i] <= level[i];
                end
            end
        end
    endgenerate

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule
`default_nettype wire

// >>> test/sfpc_flash_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfpc_defines.vh"
module sfpc_flash_checker #(
    parameter WB_CYC = 200,
    parameter WS_CYC = 200,
    parameter EB_CYC = 200,
    parameter ES_CYC = 200
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pins
    input wire logic chip_select_low,
    input wire logic serial_clock_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    // Status
    input wire logic active_power,
    input wire logic port_enabled,
    input wire logic cycle_busy,
    input wire logic [1:0] job_kind,
    input wire logic job_start
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    int busy_cnt;
    int since_fall;
    int job_len;
    logic last_clk;
    // Busy run length and cycles since a host clock fall
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt <= 0;
            since_fall <= 9;
            last_clk <= 1'b0;
        end else begin
            busy_cnt <= cycle_busy ? busy_cnt + 1 : 0;
            since_fall <= (last_clk && !serial_clock_in) ? 0 : (since_fall < 9 ? since_fall + 1 : 9);
            last_clk <= serial_clock_in;
        end
    end
    // Length allowed for the running job
    assign job_len = job_kind == `SFPC_JOB_WB ? WB_CYC : job_kind == `SFPC_JOB_WS ? WS_CYC :
                     job_kind == `SFPC_JOB_EB ? EB_CYC : ES_CYC;
    sequence s_selected;
        !chip_select_low [*6];
    endsequence
    sequence s_out_change;
        serial_data_oe && $past(serial_data_oe) && $changed(serial_data_out);
    endsequence
    a_select_enables: assert property (s_selected |-> port_enabled && active_power)
        else $error("select ignored");
    a_idle_standby: assert property (!port_enabled && !cycle_busy |-> !active_power)
        else $error("active while idle");
    a_busy_active: assert property (cycle_busy |-> active_power)
        else $error("standby while busy");
    a_start_deselected: assert property (job_start |-> !port_enabled)
        else $error("job started while selected");
    a_busy_follows: assert property (job_start |-> ##[0:1] cycle_busy [*8])
        else $error("busy missing after start");
    a_busy_bounded: assert property ($fell(cycle_busy) |-> busy_cnt <= job_len && busy_cnt + 2 > job_len)
        else $error("busy length wrong");
    a_out_after_fall: assert property (s_out_change |-> since_fall <= 6)
        else $error("output moved off falling edge");
    a_out_release: assert property ($rose(chip_select_low) |-> ##[1:8] !serial_data_oe)
        else $error("output not released");
endmodule
bind sfpc_flash sfpc_flash_checker #(.WB_CYC(WB_CYC), .WS_CYC(WS_CYC), .EB_CYC(EB_CYC), .ES_CYC(ES_CYC)) i_chk (
    .mclk(mclk), .rstn(rstn), .chip_select_low(chip_select_low), .serial_clock_in(serial_clock_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .active_power(active_power),
    .port_enabled(port_enabled), .cycle_busy(cycle_busy), .job_kind(job_kind), .job_start(job_start));
`default_nettype wire

// >>> test/sfpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfpc_host (
    // Serial port toward the flash
    output logic chip_select_low = 1'b1,
    output logic serial_clock_in = 1'b0,
    output logic serial_command_in = 1'b0,
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    // One frame at 5 MHz, clock still outside it, last eight bits returned
    task automatic frame(input logic [47:0] tx, input int nbits, output logic [7:0] rx);
        chip_select_low = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            serial_clock_in = 1'b0;
            serial_command_in = tx[47 - i];
            #100 serial_clock_in = 1'b1;
            #99 rx = {rx[6:0], serial_data_oe ? serial_data_out : 1'bx};
            #1;
        end
        serial_clock_in = 1'b0;
        #100 chip_select_low = 1'b1;
        serial_command_in = ~serial_command_in;
        #300;
    endtask
    // Error restart: a bare select pulse with the clock still
    task automatic restart();
        chip_select_low = 1'b0;
        #200 chip_select_low = 1'b1;
        #300;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfpc_defines.vh"
module tb_top;
    localparam int LEN = 200;
    localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] array_rdata = 8'h00;
    wire chip_select_low, serial_clock_in, serial_command_in, serial_data_out, serial_data_oe;
    wire active_power, port_enabled, cycle_busy, array_wstrobe, job_start;
    wire [23:0] array_addr;
    wire [7:0] array_wdata;
    wire [1:0] job_kind;
    int fails = 0;
    int tests_run = 0;
    int starts = 0;
    int n;
    logic [1:0] last_kind;
    logic [31:0] wr_word;
    logic [31:0] seed = 32'hea6f;
    logic [7:0] rx;
    always #12.5 mclk = ~mclk;
    sfpc_flash #(
        .WB_CYC(LEN),
        .WS_CYC(LEN),
        .EB_CYC(LEN),
        .ES_CYC(LEN),
        .SILICON_ID(ID_CODE)
    ) i_sfpc_flash (
        .mclk(mclk),
        .rstn(rstn),
        .chip_select_low(chip_select_low),
        .serial_clock_in(serial_clock_in),
        .serial_command_in(serial_command_in),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe),
        .active_power(active_power),
        .port_enabled(port_enabled),
        .cycle_busy(cycle_busy),
        .array_addr(array_addr),
        .array_wdata(array_wdata),
        .array_wstrobe(array_wstrobe),
        .array_rdata(array_rdata),
        .job_kind(job_kind),
        .job_start(job_start)
    );
    sfpc_host i_sfpc_host (
        .chip_select_low(chip_select_low),
        .serial_clock_in(serial_clock_in),
        .serial_command_in(serial_command_in),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe)
    );
    // Record job starts and array writes
    always @(posedge mclk) begin
        if (job_start === 1'b1) begin
            starts <= starts + 1;
            last_kind <= job_kind;
        end
        if (array_wstrobe === 1'b1) wr_word <= {array_addr, array_wdata};
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] status(input logic busy, input logic wel);
        logic [7:0] st;
        st = 8'h00;
        st[`SFPC_SR_BUSY_BIT] = busy;
        st[`SFPC_SR_WEL_BIT] = wel;
        return st;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tx(input logic [47:0] v, input int nb);
        i_sfpc_host.frame(v, nb, rx);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #2 rstn = 1'b1;
        repeat (4) @(posedge mclk);
        #2 tx({`SFPC_OP_RDSR, 40'h0}, 16);
        check("status_idle", status(0, 0), rx);
        // Every job kind twice, with random bytes for write, status write and sector erase
        for (int k = 0; k < 8; k++) begin
            seed = xorshift(seed);
            n = starts;
            tx({`SFPC_OP_WREN, 40'h0}, 8);
            case (k % 4)
                0: tx({`SFPC_OP_WRITE, seed, 8'h00}, 40);
                1: tx({`SFPC_OP_WRSR, seed, 8'h00}, 16);
                2: tx({`SFPC_OP_EBULK, seed, 8'h00}, 8);
                default: tx({`SFPC_OP_ESECT, seed, 8'h00}, 32);
            endcase
            check("job_start", n + 1, starts);
            check("job_kind", k % 4, last_kind);
            check("busy_deselected", 2'b11, {cycle_busy, active_power});
            tx({`SFPC_OP_RDSR, 40'h0}, 16);
            check("status_busy", 1, rx[`SFPC_SR_BUSY_BIT]);
            for (n = 0; n < 2 * LEN && cycle_busy !== 1'b0; n++) @(posedge mclk);
            if (n == 2 * LEN) begin
                check("busy_timeout", 0, cycle_busy);
                print_verdict();
            end
            #2 check("standby", 0, active_power);
            tx({`SFPC_OP_RDSR, 40'h0}, 16);
            check("status_done", status(0, 0), rx);
            if (k % 4 == 0) check("write_word", seed, wr_word);
        end
        // Select raised one bit short of a data byte, the first and then the second
        n = starts;
        tx({`SFPC_OP_WREN, 40'h0}, 8);
        tx({`SFPC_OP_WRITE, seed, 8'h00}, 39);
        tx({`SFPC_OP_WRITE, seed, 8'h00}, 47);
        repeat (20) @(posedge mclk);
        check("partial_dropped", n, starts);
        // Restart pulse; the write latch survives until disabled
        #2 i_sfpc_host.restart();
        tx({`SFPC_OP_RDSR, 40'h0}, 16);
        check("status_latched", status(0, 1), rx);
        tx({`SFPC_OP_WRDI, 40'h0}, 8);
        tx({`SFPC_OP_RDSR, 40'h0}, 16);
        check("status_disabled", status(0, 0), rx);
        tx({`SFPC_OP_ESECT, seed, 8'h00}, 32);
        check("erase_refused", n, starts);
        tx({`SFPC_OP_RDID, 40'h0}, 40);
        check("silicon_id", ID_CODE, rx);
        // Array read of a random byte
        seed = xorshift(seed);
        @(posedge mclk);
        #2 array_rdata = seed[7:0];
        tx({`SFPC_OP_READ, seed, 8'h00}, 40);
        check("read_data", seed[7:0], rx);
        check("released", 0, serial_data_oe);
        print_verdict();
    end
endmodule
`default_nettype wire
